// *** ird_cpu_model.sv ***
// Purpose: processor side of the request link
// Assumes: tasks entered just after a rising edge
// Notes:   behavioural, driven by bench task calls
`timescale 1ns/10ps
module ird_cpu_model (
  input  wire logic              clock_i,
  input  wire ird_pkg::ird_ans_s ans_i,
  output      ird_pkg::ird_req_s req_o
);
  initial req_o = '0;
  // ==========================================================
  // one strobe, resent while retry refuses it
  task automatic send(input logic [2:0] k, input logic [31:0] w, output logic [3:0] cc);
    cc = 4'h0;
    for (int n = 0; n <= 800; n += 40) begin
      req_o <= {1'b1, k, w};
      @(posedge clock_i);
      req_o.valid <= 1'b0;
      if (ans_i.busy === 1'b1 && (k == 3'h0 || k == 3'h3)) cc = 4'h1;
      if (ans_i.retry !== 1'b1 || cc != 4'h0) return;
      repeat (39) @(posedge clock_i);
    end
    cc = 4'h1;
  endtask
  // ==========================================================
  // advance then matching request
  task automatic xfer(input logic [2:0] k, input logic [31:0] w, input int slow,
                      output logic [31:0] r);
    logic [3:0] cc;
    r = 32'h2000_0000;
    send(k, w, cc);
    for (int t = 0; t < 60 && ans_i.ready !== 1'b1; t++) @(posedge clock_i);
    if (cc == 4'h0 && ans_i.ready === 1'b1) begin
      repeat (slow) @(posedge clock_i);
      send(k + 3'h1, w, cc);
      for (int t = 0; t < 9 && ans_i.drt_valid !== 1'b1; t++) @(posedge clock_i);
      if (ans_i.drt_valid === 1'b1) r = ans_i.data_return_word;
    end
    if (cc != 4'h0) r = {cc, 28'h0};
  endtask
endmodule

// *** ird_decoder.sv ***
// Purpose: device end of processor to io processor transfer requests
// Assumes: requests arrive as one-cycle valid pulses, synchronous
// Notes:   setup registers reached over ahb-lite, zero wait states
// Operation
// - advance request: prepare, raise ready; processor then sends matching request
// - retry refuses every transfer, under software control, held at most 20 us
// - busy lasts at least 20 us, refuses only the advance transfers
// - controller still busy: answer condition code one in bits 0-3; the decoder ignores the advance instead, and ird_cpu_model sets code one
// - decode the function codes; 1, 9, A, B, F unused
// - answer word: condition code bits 0-3, status address bits 8-31
// - condition code values as assigned, others reserved
// - never return codes 0 or 1; code 2 is processor only
// - status stored only for start, test, halt with pending status
// - missing feature gives unsupported transaction
// - identity reply: F, zero, 010, model field
// - dropped start reports no channel end or device end
// - test tries to dequeue pending status
// - stop suppresses chaining flags, operation ends normally
// - halt sends orderly termination request to controller
// - controller reset immediate, no status generated
// - interrupt level load accepted any time, repeatedly
// - enable and disable normal io interrupts
// - activate blocks lower priority interrupt levels
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module ird_decoder #(
  parameter logic [3:0] ID_MODEL = 4'h6  // arbitrary model value
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire ird_pkg::ird_req_s    req_i,
  output      ird_pkg::ird_ans_s    ans_o,
  output      ird_pkg::ird_act_s    act_o,
  output      logic                 irq_en_o,
  output      logic                 irq_block_o,
  output      logic [6:0]           irq_level_o,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic                 hready_i,
  input  wire logic [31:0]          hwdata_i,
  output      logic [31:0]          hrdata_o,
  output      logic                 hreadyout_o,
  output      logic                 hresp_o
);

  // ==========================================================
  // state
  localparam logic [ird_pkg::CNT_W-1:0] RT_MAX =
    ird_pkg::CNT_W'(ird_pkg::RETRY_MAX_CYC);
  localparam logic [ird_pkg::CNT_W-1:0] BZ_MIN =
    ird_pkg::CNT_W'(ird_pkg::BUSY_MIN_CYC);
  localparam logic [ird_pkg::PREP_W-1:0] PREP_END =
    ird_pkg::PREP_W'(ird_pkg::PREP_CYC - 1);

  typedef struct packed {
    ird_pkg::ird_state_e         fsm;
    logic [ird_pkg::PREP_W-1:0]  prep;
    logic                        adv_irq;
    logic [ird_pkg::CNT_W-1:0]   rt_cnt;
    logic [ird_pkg::CNT_W-1:0]   bz_cnt;
    logic                        rt_req;
    logic                        bz_req;
    ird_pkg::ird_ans_s           ans;
    ird_pkg::ird_act_s           act;
    logic                        irq_en;
    logic                        irq_blk;
    logic [ird_pkg::LVL_W-1:0]   irq_lvl;
    logic [3:0]                  last_fn;
    logic [ird_pkg::ADDR_W-1:0]  pend_addr;
    logic                        pend_vld;
    logic                        pend_ce;
    logic                        pend_de;
    logic [15:0]                 feat;
    logic                        subch_busy;
    logic                        a_wr;
    logic [7:0]                  a_addr;
    logic [31:0]                 hrdata;
    logic                        hready;
    logic                        hresp;
  } ird_st_s;

  ird_st_s r;
  ird_st_s n;

  // ==========================================================
  // decoding helpers
  function automatic logic fn_defined(input logic [3:0] fn);
    logic ok;
    ok = 1'b0;
    unique case (fn)
      ird_pkg::FN_IDENT, ird_pkg::FN_START, ird_pkg::FN_LOAD,
      ird_pkg::FN_TEST,  ird_pkg::FN_STOP,  ird_pkg::FN_HALT,
      ird_pkg::FN_CRST,  ird_pkg::FN_LVL,   ird_pkg::FN_EN,
      ird_pkg::FN_DIS,   ird_pkg::FN_ACT:   ok = 1'b1;
      default:                              ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic fn_stores(input logic [3:0] fn);
    return (fn == ird_pkg::FN_START) || (fn == ird_pkg::FN_TEST) ||
           (fn == ird_pkg::FN_HALT);
  endfunction

  // ==========================================================
  // next state
  logic [3:0]                 fn;
  logic [ird_pkg::ADDR_W-1:0] par;
  logic [3:0]                 cc;
  logic [ird_pkg::ADDR_W-1:0] addr;
  logic                       take;
  logic                       a_sel;

  always_comb begin
    n = r;
    n.act = '0;
    n.ans.drt_valid = 1'b0;
    fn = req_i.data[ird_pkg::FN_LO +: 4];
    par = req_i.data[ird_pkg::ADDR_W-1:0];
    cc = ird_pkg::CC_ACCEPT;
    addr = par;

    if (!r.rt_req) begin
      n.rt_cnt = '0;
    end else if (r.rt_cnt != RT_MAX) begin
      n.rt_cnt = r.rt_cnt + 1'b1;
    end
    n.ans.retry = r.rt_req && (n.rt_cnt != RT_MAX);

    if (!r.ans.busy) begin
      n.bz_cnt = '0;
    end else if (r.bz_cnt != BZ_MIN) begin
      n.bz_cnt = r.bz_cnt + 1'b1;
    end
    n.ans.busy = r.bz_req || (r.ans.busy && (r.bz_cnt != BZ_MIN));

    take = req_i.valid && !r.ans.retry;

    unique case (r.fsm)
      ird_pkg::S_IDLE: begin
        if (take && !r.ans.busy &&
            (req_i.kind == ird_pkg::XF_ADV_STAT ||
             req_i.kind == ird_pkg::XF_ADV_IRQ)) begin
          n.fsm = ird_pkg::S_PREP;
          n.prep = '0;
          n.adv_irq = (req_i.kind == ird_pkg::XF_ADV_IRQ);
        end
      end
      ird_pkg::S_PREP: begin
        n.prep = r.prep + 1'b1;
        if (r.prep == PREP_END) begin
          n.fsm = ird_pkg::S_RDY;
          n.ans.ready = 1'b1;
        end
      end
      ird_pkg::S_RDY: begin
        if (take && r.adv_irq && req_i.kind == ird_pkg::XF_IRQ) begin
          if (req_i.data[ird_pkg::DEACT_BIT]) begin
            n.irq_blk = 1'b0;
          end
          n.fsm = ird_pkg::S_IDLE;
          n.ans.ready = 1'b0;
          n.ans.drt_valid = 1'b1;
          n.ans.data_return_word = '0;
        end else if (take && !r.adv_irq &&
                     req_i.kind == ird_pkg::XF_STAT) begin
          n.fsm = ird_pkg::S_IDLE;
          n.ans.ready = 1'b0;
          n.ans.drt_valid = 1'b1;
          n.last_fn = fn;
          if (!fn_defined(fn) || !r.feat[fn]) begin
            cc = ird_pkg::CC_UNSUP;
          end else if (r.pend_vld && fn_stores(fn)) begin
            cc = ird_pkg::CC_STORED;
            addr = r.pend_addr;
            if (fn == ird_pkg::FN_TEST) begin
              n.pend_vld = 1'b0;
              n.act.test_deq = 1'b1;
            end
          end else if (r.subch_busy && (fn == ird_pkg::FN_START ||
                       fn == ird_pkg::FN_LOAD)) begin
            cc = ird_pkg::CC_SUBCH_BUSY;
          end else begin
            unique case (fn)
              ird_pkg::FN_START: n.act.start = 1'b1;
              ird_pkg::FN_LOAD:  n.act.prog_load = 1'b1;
              ird_pkg::FN_TEST:  n.act.test_deq = 1'b1;
              ird_pkg::FN_STOP:  n.act.stop_chain = 1'b1;
              ird_pkg::FN_HALT:  n.act.halt_term = 1'b1;
              ird_pkg::FN_CRST:  n.act.ctl_reset = 1'b1;
              ird_pkg::FN_LVL: begin
                n.irq_lvl = par[ird_pkg::LVL_W-1:0];
                n.act.lvl_load = 1'b1;
              end
              ird_pkg::FN_EN:    n.irq_en = 1'b1;
              ird_pkg::FN_DIS:   n.irq_en = 1'b0;
              ird_pkg::FN_ACT:   n.irq_blk = 1'b1;
              default:           n.irq_blk = r.irq_blk;
            endcase
          end
          n.ans.data_return_word = {cc, 4'h0, addr};
          if (fn == ird_pkg::FN_IDENT && r.feat[fn]) begin
            n.ans.data_return_word = {16'h0, ird_pkg::ID_PROTO, 1'b0,
                         ird_pkg::ID_TYPE, ID_MODEL, 4'h0};
          end
        end
      end
      default: begin
        n.fsm = ird_pkg::S_IDLE;
        n.ans.ready = 1'b0;
      end
    endcase

    // ahb address phase
    a_sel = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'b010);
    n.a_wr = a_sel && hwrite_i;
    n.a_addr = haddr_i[7:0];
    n.hready = 1'b1;
    if (a_sel && !hwrite_i) begin
      unique case (haddr_i[7:0])
        ird_pkg::A_CTRL:  n.hrdata = {30'h0, r.bz_req, r.rt_req};
        ird_pkg::A_STAT:  n.hrdata = {9'h0, r.irq_lvl, r.last_fn, 4'h0,
                                      r.irq_blk, r.irq_en, r.ans.busy,
                                      r.ans.retry, r.ans.ready, r.fsm};
        ird_pkg::A_PEND:  n.hrdata = {5'h0, r.pend_de, r.pend_ce,
                                      r.pend_vld, r.pend_addr};
        ird_pkg::A_FEAT:  n.hrdata = {16'h0, r.feat};
        ird_pkg::A_SUBCH: n.hrdata = {31'h0, r.subch_busy};
        default:          n.hrdata = '0;
      endcase
    end

    // ahb data phase; software sets win over clears above
    if (r.a_wr) begin
      unique case (r.a_addr)
        ird_pkg::A_CTRL: begin
          n.rt_req = hwdata_i[0];
          n.bz_req = hwdata_i[1];
          if (hwdata_i[2]) begin
            n.pend_ce = 1'b0;
            n.pend_de = 1'b0;
          end
        end
        ird_pkg::A_PEND: begin
          n.pend_addr = hwdata_i[ird_pkg::ADDR_W-1:0];
          n.pend_vld = hwdata_i[24] | n.pend_vld & hwdata_i[24];
          n.pend_ce = hwdata_i[25];
          n.pend_de = hwdata_i[26];
        end
        ird_pkg::A_FEAT:  n.feat = hwdata_i[15:0];
        ird_pkg::A_SUBCH: n.subch_busy = hwdata_i[0];
        default:          n.feat = n.feat;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.fsm <= ird_pkg::S_IDLE;
      r.feat <= ird_pkg::FEAT_RST;
      r.hready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign ans_o       = r.ans;
  assign act_o       = r.act;
  assign irq_en_o    = r.irq_en;
  assign irq_block_o = r.irq_blk;
  assign irq_level_o = r.irq_lvl;
  assign hrdata_o    = r.hrdata;
  assign hreadyout_o = r.hready;
  assign hresp_o     = r.hresp;

endmodule

// *** ird_pkg.sv ***
// Purpose: shared constants and carriers for the io request decoder
// Assumes: 40 MHz clock, big-endian bit numbering on the request bus
// Notes:   bit n of the request word sits at vector index 31-n
package ird_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS        = 25;
  localparam int RETRY_MAX_NS  = 20000;
  localparam int BUSY_MIN_NS   = 20000;
  localparam int RETRY_MAX_CYC = RETRY_MAX_NS / CLK_NS;
  localparam int BUSY_MIN_CYC  = (BUSY_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PREP_CYC      = 2;
  localparam int CNT_W         = 10;
  localparam int PREP_W        = 2;

  // ==========================================================
  // transfer kinds
  typedef logic [2:0] ird_xfer_t;
  localparam ird_xfer_t XF_ADV_STAT = 3'h0;
  localparam ird_xfer_t XF_STAT     = 3'h1;
  localparam ird_xfer_t XF_WORD     = 3'h2;
  localparam ird_xfer_t XF_ADV_IRQ  = 3'h3;
  localparam ird_xfer_t XF_IRQ      = 3'h4;

  // ==========================================================
  // function codes and condition codes
  localparam logic [3:0] FN_IDENT = 4'h0;
  localparam logic [3:0] FN_START = 4'h2;
  localparam logic [3:0] FN_LOAD  = 4'h3;
  localparam logic [3:0] FN_TEST  = 4'h4;
  localparam logic [3:0] FN_STOP  = 4'h5;
  localparam logic [3:0] FN_HALT  = 4'h6;
  localparam logic [3:0] FN_CRST  = 4'h7;
  localparam logic [3:0] FN_LVL   = 4'h8;
  localparam logic [3:0] FN_EN    = 4'hc;
  localparam logic [3:0] FN_DIS   = 4'hd;
  localparam logic [3:0] FN_ACT   = 4'he;
  localparam logic [3:0] CC_SUBCH_BUSY = 4'h3;
  localparam logic [3:0] CC_STORED     = 4'h4;
  localparam logic [3:0] CC_UNSUP      = 4'h5;
  localparam logic [3:0] CC_ACCEPT     = 4'h8;

  // ==========================================================
  // word fields
  localparam int FN_LO     = 24;
  localparam int CC_LO     = 28;
  localparam int ADDR_W    = 24;
  localparam int LVL_W     = 7;
  localparam int DEACT_BIT = 3;
  localparam logic [3:0] ID_PROTO = 4'hf;
  localparam logic [2:0] ID_TYPE  = 3'b010;

  // ==========================================================
  // register map and reset values
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_STAT   = 8'h04;
  localparam logic [7:0]  A_PEND   = 8'h08;
  localparam logic [7:0]  A_FEAT   = 8'h0c;
  localparam logic [7:0]  A_SUBCH  = 8'h10;
  localparam logic [15:0] FEAT_RST = 16'h71fd;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic      valid;
    ird_xfer_t kind;
    logic [31:0] data;
  } ird_req_s;

  typedef struct packed {
    logic        ready;
    logic        retry;
    logic        busy;
    logic        drt_valid;
    logic [31:0] data_return_word;
  } ird_ans_s;

  typedef struct packed {
    logic start;
    logic prog_load;
    logic test_deq;
    logic stop_chain;
    logic halt_term;
    logic ctl_reset;
    logic lvl_load;
  } ird_act_s;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_PREP = 3'b010,
    S_RDY  = 3'b100
  } ird_state_e;

endpackage

// *** ird_props.sv ***
// Purpose: link answer checks for ird_decoder
// Assumes: one clock, asynchronous active high reset
// Notes:   bound to the decoder top
`timescale 1ns/10ps
module ird_props (
  input wire logic              clock_i,
  input wire logic              rst_i,
  input wire ird_pkg::ird_req_s req_i,
  input wire ird_pkg::ird_ans_s ans_o,
  input wire ird_pkg::ird_act_s act_o
);
  // ==========================================================
  // helper state
  logic [9:0] rcnt;
  logic [9:0] bcnt;
  logic [2:0] adv_k;
  logic [2:0] last_k;
  logic [3:0] last_fn;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rcnt    <= 10'h000;
      bcnt    <= 10'h000;
      adv_k   <= 3'h0;
      last_k  <= 3'h0;
      last_fn <= 4'h0;
    end else begin
      rcnt    <= ans_o.retry ? rcnt + 10'h001 : 10'h000;
      bcnt    <= !ans_o.busy ? 10'h000 : (&bcnt) ? bcnt : bcnt + 10'h001;
      last_k  <= req_i.kind;
      last_fn <= req_i.data[27:24];
      if (req_i.valid && !ans_o.ready) begin
        adv_k <= req_i.kind;
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // properties
  sequence s_match;
    ans_o.ready && req_i.valid && !ans_o.retry && req_i.kind == adv_k + 3'h1;
  endsequence
  sequence s_stat;
    ans_o.drt_valid && last_k == 3'h1;
  endsequence
  property p_ready;
    $rose(ans_o.ready) |-> $past(req_i.valid, 3) && (adv_k == 3'h0 || adv_k == 3'h3);
  endproperty
  property p_ans;
    s_match |=> ans_o.drt_valid && !ans_o.ready ##1 !ans_o.drt_valid;
  endproperty
  property p_refuse;
    ans_o.retry && req_i.valid |=> !ans_o.drt_valid && act_o == '0;
  endproperty
  property p_retry;
    ans_o.retry |-> rcnt < ird_pkg::RETRY_MAX_CYC;
  endproperty
  property p_busy;
    $fell(ans_o.busy) |-> bcnt >= ird_pkg::BUSY_MIN_CYC;
  endproperty
  property p_cc;
    s_stat ##0 last_fn != 4'h0 |-> ans_o.data_return_word[31:28] inside {4'h3, 4'h4, 4'h5, 4'h8};
  endproperty
  property p_stored;
    s_stat ##0 ans_o.data_return_word[31:28] == 4'h4 |-> last_fn inside {4'h2, 4'h4, 4'h6};
  endproperty
  property p_act;
    act_o != '0 |-> ans_o.drt_valid;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready without advance");
  a_ans: assert property (p_ans)
    else $error("no single answer pulse");
  a_refuse: assert property (p_refuse)
    else $error("request taken during retry");
  a_retry: assert property (p_retry)
    else $error("retry held too long");
  a_busy: assert property (p_busy)
    else $error("busy too short");
  a_cc: assert property (p_cc)
    else $error("illegal condition code");
  a_stored: assert property (p_stored)
    else $error("status stored on wrong function");
  a_act: assert property (p_act)
    else $error("action outside answer");
endmodule

bind ird_decoder ird_props i_ird_props (.clock_i(clock_i), .rst_i(rst_i), .req_i(req_i),
  .ans_o(ans_o), .act_o(act_o));

// *** tb_top.sv ***
// Purpose: self-checking bench for ird_decoder
// Assumes: 40 MHz clock, zero-wait register bus
// Notes:   random parameters from a fixed seed
`timescale 1ns/10ps
module tb_top;
  localparam logic [3:0] MODEL = 4'h9;  // arbitrary model value
  logic              clock_i  = 1'b0;
  logic              rst_i    = 1'b1;
  logic              hsel     = 1'b0;
  logic              hwrite   = 1'b0;
  logic [1:0]        htrans   = 2'h0;
  logic [31:0]       haddr    = 32'h0;
  logic [31:0]       hwdata   = 32'h0;
  logic [31:0]       hrdata;
  logic              hready;
  logic              hresp;
  logic              irq_en;
  logic              irq_block;
  logic [6:0]        irq_level;
  logic [6:0]        last_act = 7'h0;
  ird_pkg::ird_req_s req;
  ird_pkg::ird_ans_s ans;
  ird_pkg::ird_act_s act;
  int                err_count = 0;
  int                checked   = 0;
  int                seed      = 23;
  ird_decoder #(.ID_MODEL(MODEL)) i_ird_decoder (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
    .ans_o(ans), .act_o(act), .irq_en_o(irq_en), .irq_block_o(irq_block),
    .irq_level_o(irq_level), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
  ird_cpu_model i_ird_cpu_model (.clock_i(clock_i), .ans_i(ans), .req_o(req));
  initial forever #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) if (ans.drt_valid === 1'b1) last_act <= act;
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clock_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic op(input logic [3:0] f, input logic [23:0] p, output logic [31:0] r);
    i_ird_cpu_model.xfer(3'h0, {4'h0, f, p}, $random(seed) & 3, r);
    @(posedge clock_i);
  endtask
  function automatic logic [3:0] exp_cc(input logic [3:0] f, input logic [15:0] ft,
                                         input logic pd, input logic sb);
    if (!ft[f]) return ird_pkg::CC_UNSUP;
    if (pd && (f == 4'h2 || f == 4'h4 || f == 4'h6)) return ird_pkg::CC_STORED;
    if (sb && (f == 4'h2 || f == 4'h3)) return ird_pkg::CC_SUBCH_BUSY;
    return ird_pkg::CC_ACCEPT;
  endfunction
  function automatic logic [6:0] exp_act(input logic [3:0] f);
    return (f inside {[4'h2:4'h8]}) ? 7'h40 >> (f - 4'h2) : 7'h0;
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    summarize();
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] r;
    logic [31:0] p;
    logic [3:0]  f;
    logic        pd;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk(32'({irq_en, irq_block, irq_level, ans.ready, ans.retry, ans.busy}), 32'h0);
    chk(32'({act, ans.drt_valid, hresp, hready}), 32'h1);
    ahb(1'b0, ird_pkg::A_FEAT, 32'h0, r);
    chk(r, {16'h0, ird_pkg::FEAT_RST});
    ahb(1'b0, ird_pkg::A_STAT, 32'h0, r);
    chk(r, 32'h1);
    ahb(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    for (int n = 0; n < 32; n++) begin
      f = n[3:0];
      p = $random(seed);
      op(f, p[23:0], r);
      if (f == 4'h0) chk(32'(r[15:4]), {20'h0, 4'hf, 1'b0, 3'b010, MODEL});
      else chk(32'(r[31:28]), 32'(exp_cc(f, ird_pkg::FEAT_RST, 1'b0, 1'b0)));
      chk(32'(last_act), 32'(exp_act(f)));
      if (f == 4'h8) chk(32'(irq_level), 32'(p[6:0]));
      if (f == 4'hc || f == 4'hd) chk(32'(irq_en), 32'(f == 4'hc));
      if (f == 4'he) chk(32'(irq_block), 32'h1);
    end
    i_ird_cpu_model.xfer(3'h3, 32'h0000_0008, 0, r);
    chk(r, 32'h0);
    @(posedge clock_i);
    chk(32'(irq_block), 32'h0);
    ahb(1'b1, ird_pkg::A_PEND, {8'h01, p[23:0]}, r);
    pd = 1'b1;
    for (int i = 0; i < 5; i++) begin
      f = 4'(20'h64452 >> (4 * i));
      op(f, 24'h0, r);
      chk(32'(r[31:28]), 32'(exp_cc(f, ird_pkg::FEAT_RST, pd, 1'b0)));
      if (pd && f != 4'h5) chk(32'(r[23:0]), 32'(p[23:0]));
      if (f == 4'h4) pd = 1'b0;
    end
    ahb(1'b1, ird_pkg::A_SUBCH, 32'h1, r);
    for (int i = 2; i < 5; i++) begin
      op(i[3:0], 24'h0, r);
      chk(32'(r[31:28]), 32'(exp_cc(i[3:0], ird_pkg::FEAT_RST, 1'b0, 1'b1)));
    end
    ahb(1'b1, ird_pkg::A_SUBCH, 32'h0, r);
    ahb(1'b1, ird_pkg::A_FEAT, {16'h0, ird_pkg::FEAT_RST & 16'hffdf}, r);
    op(4'h5, 24'h0, r);
    chk(32'(r[31:28]), 32'(ird_pkg::CC_UNSUP));
    ahb(1'b1, ird_pkg::A_PEND, 32'h0600_0000, r);
    ahb(1'b1, ird_pkg::A_CTRL, 32'h4, r);
    repeat (2) @(posedge clock_i);
    ahb(1'b0, ird_pkg::A_PEND, 32'h0, r);
    chk(32'(r[26:25]), 32'h0);
    ahb(1'b1, ird_pkg::A_CTRL, 32'h2, r);
    repeat (4) @(posedge clock_i);
    chk(32'(ans.busy), 32'h1);
    op(4'h2, 24'h0, r);
    chk(32'(r[31:28]), 32'h1);
    ahb(1'b1, ird_pkg::A_CTRL, 32'h0, r);
    for (int t = 0; t < 900 && ans.busy !== 1'b0; t++) @(posedge clock_i);
    ahb(1'b1, ird_pkg::A_CTRL, 32'h1, r);
    repeat (4) @(posedge clock_i);
    chk(32'(ans.retry), 32'h1);
    op(4'h8, 24'h55, r);
    chk(32'({r[31:28], irq_level}), 32'({ird_pkg::CC_ACCEPT, 7'h55}));
    ahb(1'b1, ird_pkg::A_CTRL, 32'h0, r);
    summarize();
  end
endmodule
